// ---- logic/eiwl_pkg.sv ----
package eiwl_pkg;
   // vector locations
   localparam logic [15:0] EIWL_VEC_PROG_IRQ = 16'h203c;
   localparam logic [15:0] EIWL_VEC_NMI      = 16'h203e;
   // state time of the core, in ns, and rounded up to whole clocks
   localparam int          EIWL_STATE_NS     = 20;
   localparam int          EIWL_CLK_NS       = 10;
   localparam logic [3:0]  EIWL_STATE_CYC    = 4'((EIWL_STATE_NS + EIWL_CLK_NS - 1) / EIWL_CLK_NS);
   localparam logic [3:0]  EIWL_CNT_ZERO     = 4'h0;
   localparam logic [3:0]  EIWL_CNT_ONE      = 4'h1;

   // power modes of the core
   typedef enum logic [2:0] {
      EIWL_NORMAL    = 3'h1,
      EIWL_IDLE      = 3'h2,
      EIWL_POWERDOWN = 3'h4
   } eiwl_mode_t;

   // protection control register fields seen by this block
   typedef struct packed {
      logic progIrqLevel;   // 1 sampled level, 0 edge
      logic progIrqHigh;    // 1 rising/high, 0 falling/low
      logic progIrqEnable;
   } eiwl_cfg_t;

   // request towards the instruction sequencer
   typedef struct packed {
      logic        valid;
      logic [15:0] vector;
      logic        resumeNext;  // continue after the idle_powerdown_instruction
   } eiwl_req_t;
endpackage

// ---- logic/eiwl_ext_irq_wake.sv ----
// Operation
// RQ1: software selects edge or sampled level trigger for programmable_ext_irq_input.
// RQ2: software selects rising/high or falling/low as the active sense.
// RQ3: programmable interrupt vectors through location 203CH.
// RQ4: idle plus enabled request wakes, runs service, then resumes after idle entry; an edge request in the same cycle as an nmi hit is dropped.
// RQ5: powerdown wakes to normal mode on a valid programmable request.
// RQ6: after powerdown wake, service if enabled, else continue after entry instruction.
// RQ7: normal mode rising edge on nonmaskable input vectors through 203EH.
// RQ8: outside logic holds nonmaskable input high longer than one state time.
// RQ9: idle mode nonmaskable rising edge wakes, runs service, then resumes.
// RQ10: in powerdown the nonmaskable input alone never wakes the device.
// RQ11: nonmaskable detection cannot be disabled in normal or idle mode.
`timescale 1ns/1ns
module eiwl_ext_irq_wake
   import eiwl_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   // pins, asynchronous
   input  wire logic       progExtIrqPin,
   input  wire logic       nmiPin,
   // from core
   input  wire eiwl_cfg_t  cfg,
   input  wire logic       enterIdle,
   input  wire logic       enterPowerdown,
   input  wire logic       reqAck,
   // to core
   output eiwl_req_t       req,
   output eiwl_mode_t      mode,
   output logic            wake
);
   logic [1:0]  extSync_q, nmiSync_q;
   logic        extPrev_q, nmiPrev_q;
   logic [3:0]  nmiHigh_q, nmiHigh_d;
   eiwl_mode_t  mode_q, mode_d;
   eiwl_req_t   req_q, req_d;
   logic        extPend_q, extPend_d, nmiPend_q, nmiPend_d;
   logic        wake_q, wake_d;
   logic        extLvl, extHit, nmiHit;

   // a programmable hit only counts for service while software has it enabled
   function automatic logic extServe(input logic hit, input eiwl_cfg_t c);
      return hit && c.progIrqEnable;
   endfunction

   // synchronisers; only the second stage feeds logic
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         extSync_q <= 2'h0;
         nmiSync_q <= 2'h0;
         extPrev_q <= 1'b0;
         nmiPrev_q <= 1'b0;
      end else begin
         extSync_q <= {extSync_q[0], progExtIrqPin};
         nmiSync_q <= {nmiSync_q[0], nmiPin};
         extPrev_q <= extSync_q[1];
         nmiPrev_q <= nmiSync_q[1];
      end
   end

   always_comb begin
      extLvl = cfg.progIrqHigh ? extSync_q[1] : !extSync_q[1]; // see RQ2
      extHit = cfg.progIrqLevel ? extLvl                         // see RQ1
                                : (extLvl && (extPrev_q != extSync_q[1]));
      // rising edge counted once the level has stood a full state time
      nmiHit = nmiSync_q[1] && (nmiHigh_q == EIWL_STATE_CYC - EIWL_CNT_ONE); // see RQ8
   end

   // pulses shorter than a state time may be lost; outside logic must hold the pin
   always_comb begin
      nmiHigh_d = EIWL_CNT_ZERO;
      if (nmiSync_q[1] && !nmiPrev_q) begin
         nmiHigh_d = EIWL_CNT_ONE;
      end else if (nmiSync_q[1] && nmiHigh_q != EIWL_CNT_ZERO && nmiHigh_q < EIWL_STATE_CYC) begin
         nmiHigh_d = nmiHigh_q + EIWL_CNT_ONE;
      end
   end

   always_comb begin
      mode_d    = mode_q;
      req_d     = req_q;
      extPend_d = extPend_q;
      nmiPend_d = nmiPend_q;
      wake_d    = 1'b0;
      if (req_q.valid && reqAck) begin
         req_d.valid = 1'b0;
      end
      case (mode_q)
         EIWL_NORMAL: begin
            if (nmiHit) begin
               nmiPend_d = 1'b1; // see RQ11
            end
            // level mode re-raises after every acknowledge while the pin stays active
            if (extServe(extHit, cfg)) begin // see RQ1
               extPend_d = 1'b1;
            end
            if (enterPowerdown) begin
               mode_d = EIWL_POWERDOWN;
            end else if (enterIdle) begin
               mode_d = EIWL_IDLE;
            end
         end
         EIWL_IDLE: begin
            if (nmiHit) begin // see RQ9
               nmiPend_d = 1'b1;
               mode_d    = EIWL_NORMAL;
               wake_d    = 1'b1;
            end else if (extServe(extHit, cfg)) begin // see RQ4
               extPend_d = 1'b1;
               mode_d    = EIWL_NORMAL;
               wake_d    = 1'b1;
            end
         end
         EIWL_POWERDOWN: begin
            // nmi ignored here: the clocks are meant to be stopped
            if (extHit) begin // see RQ5 see RQ10
               mode_d    = EIWL_NORMAL;
               wake_d    = 1'b1;
               extPend_d = cfg.progIrqEnable; // see RQ6
            end
         end
         default: mode_d = EIWL_NORMAL;
      endcase
      // one request at a time, nmi first; resume flag set on every request
      if (!req_d.valid) begin
         if (nmiPend_d) begin
            req_d     = '{valid: 1'b1, vector: EIWL_VEC_NMI, resumeNext: 1'b1}; // see RQ7
            nmiPend_d = 1'b0;
         end else if (extPend_d) begin
            req_d     = '{valid: 1'b1, vector: EIWL_VEC_PROG_IRQ, resumeNext: 1'b1}; // see RQ3
            extPend_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         nmiHigh_q <= EIWL_CNT_ZERO;
         mode_q    <= EIWL_NORMAL;
         req_q     <= '0;
         extPend_q <= 1'b0;
         nmiPend_q <= 1'b0;
         wake_q    <= 1'b0;
      end else begin
         nmiHigh_q <= nmiHigh_d;
         mode_q    <= mode_d;
         req_q     <= req_d;
         extPend_q <= extPend_d;
         nmiPend_q <= nmiPend_d;
         wake_q    <= wake_d;
      end
   end

   assign req  = req_q;
   assign mode = mode_q;
   assign wake = wake_q;

   // mode changes
   a_pd_nmi_nowake: assert property (@(posedge clock) disable iff (!rst_b) // see RQ10
      (mode_q == EIWL_POWERDOWN && !extHit) |=> (mode_q == EIWL_POWERDOWN))
      else $error("powerdown left without a programmable request");

   a_pd_nmi_ignored: assert property (@(posedge clock) disable iff (!rst_b) // see RQ10
      (mode_q == EIWL_POWERDOWN && nmiHit && !nmiPend_q) |=> !nmiPend_q)
      else $error("nonmaskable request taken in powerdown");

   a_pd_wakes: assert property (@(posedge clock) disable iff (!rst_b) // see RQ5
      (mode_q == EIWL_POWERDOWN && extHit) |=> (mode_q == EIWL_NORMAL && wake_q))
      else $error("powerdown did not wake");

   a_idle_hold: assert property (@(posedge clock) disable iff (!rst_b) // see RQ4
      (mode_q == EIWL_IDLE && !nmiHit && !extServe(extHit, cfg)) |=> (mode_q == EIWL_IDLE))
      else $error("idle left without a request");

   a_idle_nmi_wake: assert property (@(posedge clock) disable iff (!rst_b) // see RQ9
      (mode_q == EIWL_IDLE && nmiHit) |=>
      (mode_q == EIWL_NORMAL && wake_q) ##[0:2] req_q.valid)
      else $error("idle nmi wake missing");

   a_idle_ext_wake: assert property (@(posedge clock) disable iff (!rst_b) // see RQ4
      (mode_q == EIWL_IDLE && extServe(extHit, cfg) && !nmiHit) |=>
      (mode_q == EIWL_NORMAL && wake_q))
      else $error("idle programmable wake missing");

   a_wake_pulse: assert property (@(posedge clock) disable iff (!rst_b) // see RQ5
      wake_q |=> !wake_q)
      else $error("wake longer than one cycle");

   // requests towards the sequencer
   a_nmi_vector: assert property (@(posedge clock) disable iff (!rst_b) // see RQ7
      (nmiHit && mode_q != EIWL_POWERDOWN && !req_q.valid) |=>
      (req_q.valid && req_q.vector == EIWL_VEC_NMI))
      else $error("nmi vector not raised");

   a_nmi_always: assert property (@(posedge clock) disable iff (!rst_b) // see RQ11
      (mode_q != EIWL_POWERDOWN && nmiHit) |=>
      (nmiPend_q || (req_q.valid && req_q.vector == EIWL_VEC_NMI)))
      else $error("nonmaskable request lost");

   a_nmi_once: assert property (@(posedge clock) disable iff (!rst_b) // see RQ8
      nmiHit |=> !nmiHit)
      else $error("one nonmaskable pulse taken twice");

   a_ext_vector: assert property (@(posedge clock) disable iff (!rst_b) // see RQ3
      (mode_q == EIWL_NORMAL && extServe(extHit, cfg) && !nmiHit && !nmiPend_q
       && !req_q.valid) |=> (req_q.valid && req_q.vector == EIWL_VEC_PROG_IRQ))
      else $error("programmable vector not raised");

   a_edge_once: assert property (@(posedge clock) disable iff (!rst_b) // see RQ1
      (!cfg.progIrqLevel && extHit) |=> (!extHit || cfg.progIrqLevel))
      else $error("edge trigger hit twice");

   a_pd_enabled: assert property (@(posedge clock) disable iff (!rst_b) // see RQ6
      (mode_q == EIWL_POWERDOWN && extHit && cfg.progIrqEnable && !nmiPend_q && !req_q.valid)
      |=> (req_q.valid && req_q.vector == EIWL_VEC_PROG_IRQ))
      else $error("enabled irq not serviced after powerdown");

   a_pd_disabled: assert property (@(posedge clock) disable iff (!rst_b) // see RQ6
      (mode_q == EIWL_POWERDOWN && extHit && !cfg.progIrqEnable && !nmiPend_q && !req_q.valid)
      |=> (!req_q.valid && !extPend_q))
      else $error("disabled irq serviced after powerdown");

   a_resume_next: assert property (@(posedge clock) disable iff (!rst_b) // see RQ9
      req_q.valid |-> req_q.resumeNext)
      else $error("request without resume flag");

   a_req_hold: assert property (@(posedge clock) disable iff (!rst_b) // see RQ7
      (req_q.valid && !reqAck) |=> (req_q.valid && $stable(req_q.vector)))
      else $error("request dropped before acknowledge");
endmodule

// ---- tb/eiwl_pin_drv.sv ----
`timescale 1ns/1ns
module eiwl_pin_drv (
   // clock
   input  wire logic clock,
   // pins
   output logic      progExtIrqPin,
   output logic      nmiPin
);
   initial begin
      progExtIrqPin = 1'b0;
      nmiPin        = 1'b0;
   end
   // four clocks, twice the state time, so the pulse cannot be missed
   task automatic pulseNmi();
      @(posedge clock);
      nmiPin <= 1'b1;
      repeat (4) @(posedge clock);
      nmiPin <= 1'b0;
   endtask
   task automatic setExt(input logic lvl);
      @(posedge clock);
      progExtIrqPin <= lvl;
   endtask
endmodule

// ---- tb/eiwl_ext_irq_wake_tb.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module eiwl_ext_irq_wake_tb
   import eiwl_pkg::*;
;
   logic clock = 1'b0;
   logic rst_b;
   logic enterIdle, enterPowerdown, reqAck;
   eiwl_cfg_t cfg;
   eiwl_req_t req;
   eiwl_mode_t mode;
   logic wake, extPin, nmiPin;
   int n_fail = 0, n_compared = 0;
   always #5 clock = ~clock;
   eiwl_pin_drv i_eiwl_pin_drv (.clock(clock), .progExtIrqPin(extPin), .nmiPin(nmiPin));
   eiwl_ext_irq_wake i_eiwl_ext_irq_wake (.clock(clock), .rst_b(rst_b),
      .progExtIrqPin(extPin), .nmiPin(nmiPin), .cfg(cfg), .enterIdle(enterIdle),
      .enterPowerdown(enterPowerdown), .reqAck(reqAck), .req(req), .mode(mode), .wake(wake));
   task automatic waitReq(input logic [15:0] vec, input logic again);
      @(negedge clock);
      for (int i = 0; i < 30 && req.valid !== 1'b1; i++) @(negedge clock);
      `CHK(req.valid, 1'b1)
      `CHK(req.vector, vec)
      `CHK(req.resumeNext, 1'b1)
      @(posedge clock) reqAck <= 1'b1;
      @(posedge clock) reqAck <= 1'b0;
      @(negedge clock) `CHK(req.valid, again)
   endtask
   task automatic enter(input logic pd);
      @(posedge clock) begin
         enterIdle <= ~pd;
         enterPowerdown <= pd;
      end
      @(posedge clock) {enterIdle, enterPowerdown} <= 2'h0;
      repeat (3) @(negedge clock);
      `CHK(mode, pd ? EIWL_POWERDOWN : EIWL_IDLE)
   endtask
   task automatic tNmiNormal();
      i_eiwl_pin_drv.pulseNmi();
      waitReq(EIWL_VEC_NMI, 1'b0);
      $display("test nmi normal done");
   endtask
   task automatic tExtEdge();
      i_eiwl_pin_drv.setExt(1'b1);
      waitReq(EIWL_VEC_PROG_IRQ, 1'b0);
      i_eiwl_pin_drv.setExt(1'b0);
      repeat (12) @(negedge clock);
      `CHK(req.valid, 1'b0)
      $display("test ext edge done");
   endtask
   task automatic tIdleLevel();
      // level, low active, disabled: an active pin must not wake idle
      @(posedge clock) cfg <= 3'h4;
      i_eiwl_pin_drv.setExt(1'b1);
      enter(1'b0);
      i_eiwl_pin_drv.setExt(1'b0);
      repeat (6) @(negedge clock);
      `CHK(mode, EIWL_IDLE)
      `CHK(req.valid, 1'b0)
      @(posedge clock) cfg <= 3'h5;
      waitReq(EIWL_VEC_PROG_IRQ, 1'b1);
      `CHK(mode, EIWL_NORMAL)
      i_eiwl_pin_drv.setExt(1'b1);
      // the level still stood for a few cycles, so one more request is pending
      waitReq(EIWL_VEC_PROG_IRQ, 1'b1);
      waitReq(EIWL_VEC_PROG_IRQ, 1'b0);
      $display("test idle level done");
   endtask
   task automatic tPowerdown();
      @(posedge clock) cfg <= 3'h4;
      enter(1'b1);
      i_eiwl_pin_drv.pulseNmi();
      repeat (20) @(negedge clock);
      `CHK(mode, EIWL_POWERDOWN)
      `CHK(req.valid, 1'b0)
      i_eiwl_pin_drv.setExt(1'b0);
      for (int i = 0; i < 30 && wake !== 1'b1; i++) @(negedge clock);
      `CHK(wake, 1'b1)
      `CHK(mode, EIWL_NORMAL)
      @(negedge clock) `CHK(wake, 1'b0)
      repeat (4) @(negedge clock);
      `CHK(req.valid, 1'b0)
      i_eiwl_pin_drv.setExt(1'b1);
      // falling edge, enabled: the wake must be followed by service
      repeat (4) @(posedge clock);
      cfg <= 3'h1;
      enter(1'b1);
      i_eiwl_pin_drv.setExt(1'b0);
      waitReq(EIWL_VEC_PROG_IRQ, 1'b0);
      `CHK(mode, EIWL_NORMAL)
      $display("test powerdown done");
   endtask
   task automatic tReset();
      enter(1'b0);
      @(posedge clock) rst_b <= 1'b0;
      @(negedge clock);
      `CHK(mode, EIWL_NORMAL)
      `CHK(req.valid, 1'b0)
      `CHK(wake, 1'b0)
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      i_eiwl_pin_drv.pulseNmi();
      waitReq(EIWL_VEC_NMI, 1'b0);
      $display("test reset done");
   endtask
   task automatic tIdleNmi();
      enter(1'b0);
      i_eiwl_pin_drv.pulseNmi();
      waitReq(EIWL_VEC_NMI, 1'b0);
      `CHK(mode, EIWL_NORMAL)
      $display("test idle nmi done");
   endtask
   task automatic give_verdict();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      rst_b <= 1'b0;
      {enterIdle, enterPowerdown, reqAck} <= 3'h0;
      cfg <= 3'h3;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      tNmiNormal();
      tExtEdge();
      tIdleLevel();
      tPowerdown();
      tIdleNmi();
      tReset();
      give_verdict();
   end
   // all tests need well under 1000 clocks
   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end
endmodule
